// *** core/bit_sync.sv ***
`default_nettype none
module bit_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Bits
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage_reg;
    logic [WIDTH-1:0] out_reg;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stage_reg <= '0;
            out_reg <= '0;
        end else begin
            stage_reg <= async_in;
            out_reg <= stage_reg;
        end
    end

    assign sync_out = out_reg;
endmodule : bit_sync
`default_nettype wire

// *** core/switch_input_supply_fault_ctrl.sv ***
`default_nettype none
// Overview of operation
// - Any supply fault entry switches off all wetting currents and halts monitoring.
// - Under-voltage entry pulls alert low, sets event flag and live status.
// - Over-voltage entry pulls alert low, sets event flag and live status.
// - Serial status carries supply-fault flag while a supply event is pending.
// - Alert released, flags cleared at chip-select rise after an interrupt read.
// - Serial link and stored state keep working through supply faults.
// - Fault held while comparator holds; no repeat interrupt once cleared.
// - Under-voltage exit pulls alert, sets event flag, clears live status.
// - Over-voltage exit pulls alert, sets event flag, clears live status.
// - After recovery polling restarts from lowest enabled input with present settings.
// - First poll cycle after recovery raises change event and sets baseline.
// - Power-on reset clears everything; controller must reprogram configuration.
// - One threshold applies to each group of four consecutive inputs.
// - Threshold field picks 2 V, 2.7 V, 3 V or 4 V.
// - Wetting current shared by pairs, except inputs 4, 5, 10, 11, 22, 23.
// - Inputs 10 to 23 only source; 0 to 9 sink when select bit set.
// - Disabled input has no wetting current and is not monitored.
// - All input enables clear after reset.
// - Wetting field picks 0, 1, 2, 5, 10 or 15 mA, resets to 0.
// - Wetting current and monitoring only while monitoring-run bit is set.
// - Alert is active-low open drain, driven only while asserted.
module switch_input_supply_fault_ctrl (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Supply comparators
    input wire logic undervolt_detect,
    input wire logic overvolt_detect,
    // Serial link
    input wire logic spi_cs_n,
    input wire logic spi_sclk,
    input wire logic spi_si,
    output logic spi_so,
    output logic spi_so_oe,
    // Alert open drain
    output logic alert_n_out,
    output logic alert_n_oe,
    // Configuration
    input wire logic monitor_run,
    input wire logic [23:0] input_enable,
    input wire logic [9:0] sink_select,
    input wire logic [11:0] threshold_group_reg,
    input wire logic [23:0] wet_current_cfg_a,
    input wire logic [20:0] wet_current_cfg_b,
    // Switch comparators
    input wire logic [23:0] switch_input_pin,
    // Drive and status
    output logic [23:0] current_source,
    output logic [9:0] current_sink,
    output logic [71:0] wet_level,
    output logic [47:0] input_threshold,
    output logic [23:0] switch_status,
    output logic monitoring_active,
    output logic undervolt_event_flag,
    output logic overvolt_event_flag,
    output logic switch_change_event,
    output logic undervolt_live_status,
    output logic overvolt_live_status,
    output logic supply_fault_serial_flag
);
    function automatic logic [3:0] wet_field(input int i);
        logic [3:0] f;
        f = 4'h0;
        if (i < 4) f = 4'(i / 2);
        else if (i == 4) f = 4'h2;
        else if (i == 5) f = 4'h3;
        else if (i < 10) f = 4'(i / 2 + 1);
        else if (i == 10) f = 4'h6;
        else if (i == 11) f = 4'h7;
        else if (i < 22) f = 4'(i / 2 + 2);
        else if (i == 22) f = 4'hD;
        else f = 4'hE;
        return f;
    endfunction : wet_field

    function automatic logic [4:0] next_enabled(input logic [23:0] en, input logic [5:0] start);
        logic [4:0] r;
        r = supply_fault_pkg::IDX_NONE;
        for (int k = 23; k >= 0; k--) begin
            if (en[k] && 6'(k) >= start) r = 5'(k);
        end
        return r;
    endfunction : next_enabled

    // Reset release
    logic [1:0] rst_pipe_reg;
    logic rst_n_s;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) rst_pipe_reg <= 2'h0;
        else rst_pipe_reg <= {rst_pipe_reg[0], 1'b1};
    end
    assign rst_n_s = rst_pipe_reg[1];

    // Input synchronisers
    logic uv_s, ov_s, cs_act_s, cs_n_s, sclk_s, si_s;
    logic [23:0] sw_s;
    // Select synced inverted so its reset value is the idle level
    bit_sync #(.WIDTH(29)) u_sync (
        .clk(clk),
        .rst_n(rst_n_s),
        .async_in({undervolt_detect, overvolt_detect, !spi_cs_n, spi_sclk, spi_si,
                   switch_input_pin}),
        .sync_out({uv_s, ov_s, cs_act_s, sclk_s, si_s, sw_s})
    );
    assign cs_n_s = !cs_act_s;

    // Serial state
    logic cs_prev_reg, cs_prev_next, sclk_prev_reg, sclk_prev_next;
    logic [3:0] bit_cnt_reg, bit_cnt_next;
    logic [7:0] cmd_reg, cmd_next, tx_reg, tx_next;
    logic read_int_reg, read_int_next, so_reg, so_next, so_oe_reg, so_oe_next;
    logic cs_fall, cs_rise, sclk_rise, sclk_fall, int_clear;
    logic [7:0] status_word, cmd_shift;

    // Supply and event state
    logic uv_live_reg, uv_live_next, ov_live_reg, ov_live_next;
    logic uv_ev_reg, uv_ev_next, ov_ev_reg, ov_ev_next, sc_ev_reg, sc_ev_next;
    logic alert_reg, alert_next, alert_out_reg, alert_out_next;
    logic fault_flag_reg, fault_flag_next;
    logic uv_change, ov_change, recovery, fault, cycle_change;

    // Poll state
    supply_fault_pkg::poll_state_type state_reg, state_next;
    logic [4:0] idx_reg, idx_next, first_idx, after_idx;
    logic [23:0] sample_reg, sample_next, stat_reg, stat_next;
    logic first_reg, first_next, active_run;

    // Drive state
    logic [23:0] src_reg, src_next;
    logic [9:0] snk_reg, snk_next;
    logic [71:0] wet_reg, wet_next;
    logic [47:0] thr_reg, thr_next;
    logic mon_reg, mon_next;

    // Serial frame handling
    always_comb begin
        cs_fall = cs_prev_reg && !cs_n_s;
        cs_rise = !cs_prev_reg && cs_n_s;
        sclk_rise = !cs_n_s && !sclk_prev_reg && sclk_s;
        sclk_fall = !cs_n_s && sclk_prev_reg && !sclk_s;
        int_clear = cs_rise && read_int_reg;
        cmd_shift = {cmd_reg[6:0], si_s};
        status_word = 8'h00;
        status_word[supply_fault_pkg::ST_FAULT] = fault_flag_reg;
        status_word[supply_fault_pkg::ST_UV_EV] = uv_ev_reg;
        status_word[supply_fault_pkg::ST_OV_EV] = ov_ev_reg;
        status_word[supply_fault_pkg::ST_SC_EV] = sc_ev_reg;
        status_word[supply_fault_pkg::ST_UV_LIVE] = uv_live_reg;
        status_word[supply_fault_pkg::ST_OV_LIVE] = ov_live_reg;
        cs_prev_next = cs_n_s;
        sclk_prev_next = sclk_s;
        bit_cnt_next = bit_cnt_reg;
        cmd_next = cmd_reg;
        tx_next = tx_reg;
        read_int_next = read_int_reg;
        so_next = so_reg;
        so_oe_next = so_oe_reg;
        if (cs_fall) begin
            tx_next = status_word;
            so_next = status_word[7];
            so_oe_next = 1'b1;
            bit_cnt_next = 4'h0;
            read_int_next = 1'b0;
        end else if (cs_rise) begin
            so_oe_next = 1'b0;
            read_int_next = 1'b0;
        end else if (sclk_rise && bit_cnt_reg < supply_fault_pkg::CMD_BITS) begin
            cmd_next = cmd_shift;
            bit_cnt_next = bit_cnt_reg + 4'h1;
            if (bit_cnt_next == supply_fault_pkg::CMD_BITS
                && cmd_shift == supply_fault_pkg::READ_INT_CMD) begin
                read_int_next = 1'b1;
            end
        end else if (sclk_fall) begin
            tx_next = {tx_reg[6:0], 1'b0};
            so_next = tx_reg[6];
        end
    end

    always_ff @(posedge clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            cs_prev_reg <= 1'b1;
            sclk_prev_reg <= 1'b0;
            bit_cnt_reg <= 4'h0;
            cmd_reg <= 8'h00;
            tx_reg <= 8'h00;
            read_int_reg <= 1'b0;
            so_reg <= 1'b0;
            so_oe_reg <= 1'b0;
        end else begin
            cs_prev_reg <= cs_prev_next;
            sclk_prev_reg <= sclk_prev_next;
            bit_cnt_reg <= bit_cnt_next;
            cmd_reg <= cmd_next;
            tx_reg <= tx_next;
            read_int_reg <= read_int_next;
            so_reg <= so_next;
            so_oe_reg <= so_oe_next;
        end
    end

    // Supply faults and event flags
    always_comb begin
        uv_live_next = uv_s;
        ov_live_next = ov_s;
        uv_change = uv_s != uv_live_reg;
        ov_change = ov_s != ov_live_reg;
        fault = uv_live_reg || ov_live_reg;
        recovery = fault && !uv_s && !ov_s;
        uv_ev_next = (uv_ev_reg && !int_clear) || uv_change;
        ov_ev_next = (ov_ev_reg && !int_clear) || ov_change;
        sc_ev_next = (sc_ev_reg && !int_clear) || cycle_change;
        alert_next = (alert_reg && !int_clear) || uv_change || ov_change || cycle_change;
        alert_out_next = !alert_next;
        fault_flag_next = uv_ev_next || ov_ev_next;
    end

    always_ff @(posedge clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            uv_live_reg <= 1'b0;
            ov_live_reg <= 1'b0;
            uv_ev_reg <= 1'b0;
            ov_ev_reg <= 1'b0;
            sc_ev_reg <= 1'b0;
            alert_reg <= 1'b0;
            alert_out_reg <= 1'b1;
            fault_flag_reg <= 1'b0;
        end else begin
            uv_live_reg <= uv_live_next;
            ov_live_reg <= ov_live_next;
            uv_ev_reg <= uv_ev_next;
            ov_ev_reg <= ov_ev_next;
            sc_ev_reg <= sc_ev_next;
            alert_reg <= alert_next;
            alert_out_reg <= alert_out_next;
            fault_flag_reg <= fault_flag_next;
        end
    end

    // Polling of enabled inputs
    always_comb begin
        active_run = monitor_run && !fault && !uv_s && !ov_s;
        first_idx = next_enabled(input_enable, 6'h00);
        after_idx = next_enabled(input_enable, {1'b0, idx_reg} + 6'h01);
        state_next = state_reg;
        idx_next = idx_reg;
        sample_next = sample_reg;
        stat_next = stat_reg;
        first_next = first_reg || recovery;
        cycle_change = 1'b0;
        case (state_reg)
            supply_fault_pkg::POLL_HALT: begin
                if (active_run && first_idx != supply_fault_pkg::IDX_NONE) begin
                    state_next = supply_fault_pkg::POLL_SCAN;
                    idx_next = first_idx;
                    sample_next = 24'h000000;
                end
            end
            supply_fault_pkg::POLL_SCAN: begin
                if (!active_run) begin
                    state_next = supply_fault_pkg::POLL_HALT;
                end else begin
                    sample_next[idx_reg] = sw_s[idx_reg] && input_enable[idx_reg];
                    if (after_idx == supply_fault_pkg::IDX_NONE) begin
                        stat_next = sample_next & input_enable;
                        cycle_change = first_reg || (stat_next != stat_reg);
                        first_next = 1'b0;
                        idx_next = first_idx;
                        sample_next = 24'h000000;
                        if (first_idx == supply_fault_pkg::IDX_NONE) begin
                            state_next = supply_fault_pkg::POLL_HALT;
                        end
                    end else begin
                        idx_next = after_idx;
                    end
                end
            end
            default: begin
                state_next = supply_fault_pkg::POLL_HALT;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            state_reg <= supply_fault_pkg::POLL_HALT;
            idx_reg <= 5'h00;
            sample_reg <= 24'h000000;
            stat_reg <= 24'h000000;
            first_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            idx_reg <= idx_next;
            sample_reg <= sample_next;
            stat_reg <= stat_next;
            first_reg <= first_next;
        end
    end

    // Wetting current and threshold drive
    always_comb begin
        logic [3:0] f;
        logic [2:0] code;
        logic on;
        f = 4'h0;
        code = 3'h0;
        on = 1'b0;
        mon_next = active_run;
        src_next = 24'h000000;
        snk_next = 10'h000;
        wet_next = 72'h0;
        thr_next = 48'h0;
        for (int i = 0; i < supply_fault_pkg::NUM_INPUTS; i++) begin
            f = wet_field(i);
            if (f < 4'(supply_fault_pkg::WET_A_FIELDS)) code = wet_current_cfg_a[f*3 +: 3];
            else code = wet_current_cfg_b[(f - 4'h8)*3 +: 3];
            if (code > supply_fault_pkg::WET_15MA) code = supply_fault_pkg::WET_0MA;
            on = active_run && input_enable[i];
            if (i < supply_fault_pkg::NUM_SINKABLE && sink_select[i]) snk_next[i] = on;
            else src_next[i] = on;
            wet_next[i*3 +: 3] = on ? code : supply_fault_pkg::WET_0MA;
            thr_next[i*2 +: 2] = threshold_group_reg[(i / 4)*2 +: 2];
        end
    end

    always_ff @(posedge clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            src_reg <= 24'h000000;
            snk_reg <= 10'h000;
            wet_reg <= 72'h0;
            thr_reg <= 48'h0;
            mon_reg <= 1'b0;
        end else begin
            src_reg <= src_next;
            snk_reg <= snk_next;
            wet_reg <= wet_next;
            thr_reg <= thr_next;
            mon_reg <= mon_next;
        end
    end

    assign spi_so = so_reg;
    assign spi_so_oe = so_oe_reg;
    assign alert_n_out = alert_out_reg;
    assign alert_n_oe = alert_reg;
    assign current_source = src_reg;
    assign current_sink = snk_reg;
    assign wet_level = wet_reg;
    assign input_threshold = thr_reg;
    assign switch_status = stat_reg;
    assign monitoring_active = mon_reg;
    assign undervolt_event_flag = uv_ev_reg;
    assign overvolt_event_flag = ov_ev_reg;
    assign switch_change_event = sc_ev_reg;
    assign undervolt_live_status = uv_live_reg;
    assign overvolt_live_status = ov_live_reg;
    assign supply_fault_serial_flag = fault_flag_reg;

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n_s);

    a_fault_drive_off: assert property (fault |=> (src_reg == 24'h0 && snk_reg == 10'h0))
        else $error("wetting current on during supply fault");
    a_uv_entry_flag: assert property ($rose(uv_live_reg) |-> uv_ev_reg && alert_reg)
        else $error("under-voltage entry not flagged");
    a_ov_entry_flag: assert property ($rose(ov_live_reg) |-> ov_ev_reg && alert_reg)
        else $error("over-voltage entry not flagged");
    a_serial_fault_bit: assert property ((uv_ev_reg || ov_ev_reg) |-> fault_flag_reg)
        else $error("supply fault serial flag missing");
    a_read_clears: assert property (int_clear && !uv_change && !ov_change && !cycle_change
        |=> !alert_reg && !uv_ev_reg && !ov_ev_reg)
        else $error("interrupt read did not clear");
    a_uv_exit_flag: assert property ($fell(uv_live_reg) |-> uv_ev_reg && alert_n_oe)
        else $error("under-voltage exit not flagged");
    a_ov_exit_flag: assert property ($fell(ov_live_reg) |-> ov_ev_reg && !alert_n_out)
        else $error("over-voltage exit not flagged");
    a_no_repeat_irq: assert property (fault && !alert_reg && uv_s == uv_live_reg
        && ov_s == ov_live_reg |=> !alert_reg)
        else $error("repeat alert while fault held");
    a_disabled_idle: assert property (!input_enable[0] ##1 !input_enable[0]
        |-> !src_reg[0] && !snk_reg[0])
        else $error("disabled input driven");
    a_run_gates_drive: assert property (!monitor_run
        |=> !mon_reg && src_reg == 24'h0 && snk_reg == 10'h0)
        else $error("monitoring while run bit low");
    a_restart_lowest: assert property (state_reg == supply_fault_pkg::POLL_HALT
        && state_next == supply_fault_pkg::POLL_SCAN |=> idx_reg == $past(first_idx))
        else $error("polling did not restart at lowest input");
    a_first_cycle_event: assert property (first_reg && cycle_change |=> sc_ev_reg && !first_reg)
        else $error("first poll cycle did not raise change");

    c_uv_cycle: cover property ($rose(uv_live_reg) ##[1:1000] $fell(uv_live_reg));
    c_int_read: cover property (int_clear);
    c_poll_change: cover property (cycle_change);
endmodule : switch_input_supply_fault_ctrl
`default_nettype wire

// *** inc/supply_fault_pkg.sv ***
`default_nettype none
package supply_fault_pkg;
    // Input arrangement
    localparam int NUM_INPUTS = 24;
    localparam int NUM_SINKABLE = 10;
    localparam int GROUP_SIZE = 4;
    localparam int NUM_GROUPS = 6;
    localparam int NUM_WET_FIELDS = 15;
    localparam int WET_A_FIELDS = 8;
    localparam int WET_B_FIELDS = 7;
    localparam int WET_W = 3;
    localparam int THR_W = 2;
    localparam int IDX_W = 5;
    localparam logic [4:0] IDX_NONE = 5'h18;
    // Wetting current codes
    localparam logic [2:0] WET_0MA = 3'h0;
    localparam logic [2:0] WET_1MA = 3'h1;
    localparam logic [2:0] WET_2MA = 3'h2;
    localparam logic [2:0] WET_5MA = 3'h3;
    localparam logic [2:0] WET_10MA = 3'h4;
    localparam logic [2:0] WET_15MA = 3'h5;
    // Threshold codes
    localparam logic [1:0] THR_2V0 = 2'h0;
    localparam logic [1:0] THR_2V7 = 2'h1;
    localparam logic [1:0] THR_3V0 = 2'h2;
    localparam logic [1:0] THR_4V0 = 2'h3;
    localparam logic [1:0] THR_RESET = THR_2V0;
    // Serial frame
    localparam int CMD_W = 8;
    localparam logic [3:0] CMD_BITS = 4'h8;
    localparam logic [7:0] READ_INT_CMD = 8'h01;
    localparam int ST_FAULT = 7;
    localparam int ST_UV_EV = 6;
    localparam int ST_OV_EV = 5;
    localparam int ST_SC_EV = 4;
    localparam int ST_UV_LIVE = 3;
    localparam int ST_OV_LIVE = 2;
    // Poll states
    typedef enum logic [1:0] {
        POLL_HALT = 2'b01,
        POLL_SCAN = 2'b10
    } poll_state_type;
endpackage : supply_fault_pkg
`default_nettype wire

// *** test/spi_host_model.sv ***
`default_nettype none
module spi_host_model (
    // Clock
    input wire logic clk,
    // Serial lines
    output logic cs_n,
    output logic sclk,
    output logic si,
    input wire logic so,
    input wire logic so_oe
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        si = 1'b0;
    end
    // One frame: command out, status in
    task automatic xfer(input logic [7:0] cmd, output logic [7:0] st);
        @(negedge clk);
        cs_n = 1'b0;
        for (int i = 7; i >= 0; i--) begin
            si = cmd[i];
            repeat (4) @(negedge clk);
            st[i] = so_oe ? so : 1'bx;
            sclk = 1'b1;
            repeat (4) @(negedge clk);
            sclk = 1'b0;
        end
        cs_n = 1'b1;
        // Released line, no pull
        si = ~si;
        repeat (6) @(negedge clk);
    endtask : xfer
endmodule : spi_host_model
`default_nettype wire

// *** test/switch_input_supply_fault_ctrl_tb.sv ***
`default_nettype none
module switch_input_supply_fault_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 0, rstn = 0, uv = 0, ov = 0, run = 0;
    logic [23:0] en = 0, pins = 0, wa = 0, src, stat, stat0;
    logic [9:0] sk = 0, snk;
    logic [11:0] thr = 0;
    logic [20:0] wb = 0;
    logic [71:0] wl;
    logic [47:0] ith;
    logic cs_n, sclk, si, so, so_oe, a_out, a_oe, mact, uvf, ovf, sce, uvl, ovl, sff;
    logic [7:0] st;
    int failures = 0, cmp_count = 0, seed = 14;
    int fmap[24] = '{0, 0, 1, 1, 2, 3, 4, 4, 5, 5, 6, 7, 8, 8, 9, 9, 10, 10, 11, 11, 12, 12, 13, 14};
    always #50 clk = ~clk;
    switch_input_supply_fault_ctrl uut (.clk(clk), .rstn(rstn), .undervolt_detect(uv),
        .overvolt_detect(ov), .spi_cs_n(cs_n), .spi_sclk(sclk), .spi_si(si), .spi_so(so),
        .spi_so_oe(so_oe), .alert_n_out(a_out), .alert_n_oe(a_oe), .monitor_run(run),
        .input_enable(en), .sink_select(sk), .threshold_group_reg(thr),
        .wet_current_cfg_a(wa), .wet_current_cfg_b(wb), .switch_input_pin(pins),
        .current_source(src), .current_sink(snk), .wet_level(wl), .input_threshold(ith),
        .switch_status(stat), .monitoring_active(mact), .undervolt_event_flag(uvf),
        .overvolt_event_flag(ovf), .switch_change_event(sce), .undervolt_live_status(uvl),
        .overvolt_live_status(ovl), .supply_fault_serial_flag(sff));
    spi_host_model host (.clk(clk), .cs_n(cs_n), .sclk(sclk), .si(si), .so(so), .so_oe(so_oe));
    task automatic close_out;
        $display("Checks %0d, mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : close_out
    task automatic chk(string n, logic [71:0] e, logic [71:0] g);
        cmp_count++;
        if (g !== e) begin
            failures++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    // Applied current code of one input
    function automatic logic [2:0] wcode(int i);
        logic [2:0] c;
        c = fmap[i] < 8 ? wa[3*fmap[i]+:3] : wb[3*(fmap[i]-8)+:3];
        return c > 3'h5 ? 3'h0 : c;
    endfunction : wcode
    task automatic cfg_check(logic act);
        logic [23:0] es;
        logic [9:0] ek;
        logic [71:0] ew;
        logic [47:0] et;
        ek = '0;
        for (int i = 0; i < 24; i++) begin
            es[i] = act & en[i] & ~(i < 10 && sk[i]);
            if (i < 10) ek[i] = act & en[i] & sk[i];
            ew[3*i+:3] = (act & en[i]) ? wcode(i) : 3'h0;
            et[2*i+:2] = thr[2*(i/4)+:2];
        end
        chk("current_source", 72'(es), 72'(src));
        chk("current_sink", 72'(ek), 72'(snk));
        chk("wet_level", ew, wl);
        chk("input_threshold", 72'(et), 72'(ith));
    endtask : cfg_check
    task automatic wait_on(int w, logic v);
        for (int n = 0; n < 80; n++) begin
            if ((w == 0 ? uvl : w == 1 ? ovl : sce) === v) return;
            @(negedge clk);
        end
        failures++;
        $display("ERROR wait signal %0d expected %b", w, v);
        close_out();
    endtask : wait_on
    initial begin
        repeat (8) @(negedge clk);
        rstn = 1;
        repeat (6) @(negedge clk);
        chk("alert_oe", 72'h0, 72'(a_oe));
        cfg_check(1'b0);
        for (int k = 0; k < 6; k++) begin
            run = 0;
            @(negedge clk);
            en = $random(seed);
            sk = $random(seed);
            thr = $random(seed);
            wa = $random(seed);
            wb = $random(seed);
            thr[5:0] = thr[5:0] | 6'h2A;
            if (k == 0) begin
                en = 24'hFFFFFF;
                wa = 24'hFAC688;
                thr = 12'hE4;
            end
            repeat (3) @(negedge clk);
            cfg_check(1'b0);
            run = 1;
            repeat (3) @(negedge clk);
            cfg_check(1'b1);
        end
        for (int kind = 0; kind < 2; kind++) begin
            pins = $random(seed);
            repeat (40) @(negedge clk);
            host.xfer(8'h01, st);
            stat0 = pins & en;
            chk("switch_status", 72'(stat0), 72'(stat));
            if (kind == 0) uv = 1;
            else ov = 1;
            wait_on(kind, 1'b1);
            chk("event_flag", 72'h1, 72'(kind ? ovf : uvf));
            chk("alert", 72'h2, 72'({a_oe, a_out}));
            chk("serial_flag", 72'h1, 72'(sff));
            repeat (2) @(negedge clk);
            chk("drive_off", 72'h0, 72'({src, snk, wl, mact}));
            pins = ~pins;
            repeat (40) @(negedge clk);
            chk("held_status", 72'(stat0), 72'(stat));
            host.xfer(8'h00, st);
            chk("status_byte", 72'(kind ? 8'hA4 : 8'hC8), 72'(st));
            chk("alert_kept", 72'h1, 72'(a_oe));
            host.xfer(8'h01, st);
            chk("cleared", 72'h0, 72'({a_oe, sff, uvf, ovf}));
            repeat (20) @(negedge clk);
            chk("no_repeat", 72'h0, 72'({a_oe, uvf, ovf}));
            uv = 0;
            ov = 0;
            wait_on(kind, 1'b0);
            chk("exit_flag", 72'h1, 72'(kind ? ovf : uvf));
            chk("exit_alert", 72'h1, 72'(a_oe));
            wait_on(2, 1'b1);
            chk("baseline", 72'(pins & en), 72'(stat));
            cfg_check(1'b1);
            host.xfer(8'h01, st);
        end
        close_out();
    end
endmodule : switch_input_supply_fault_ctrl_tb
`default_nettype wire
